// *** hdl/ppcs_consts.vh ***
// Constants for the port PHY control/status register pair.
// Assumes byte addressing of 16-bit registers at even offsets.
`ifndef PPCS_CONSTS_VH
`define PPCS_CONSTS_VH

`define PPCS_ADDR_W 8
`define PPCS_DATA_W 16

// Register byte addresses
`define PPCS_OFF_BASIC_CTRL 8'he0
`define PPCS_OFF_BASIC_STAT 8'he2
`define PPCS_OFF_ADVERTISE 8'hec
`define PPCS_OFF_PARTNER 8'hee
`define PPCS_OFF_CONTROL 8'hf6
`define PPCS_OFF_STATUS 8'hf8
`define PPCS_OFF_RSVD_LO 8'hfa
`define PPCS_OFF_RSVD_HI 8'hff

// Control register fields
`define PPCS_CR_LED_OFF 15
`define PPCS_CR_TX_DIS 14
`define PPCS_CR_RESTART 13
`define PPCS_CR_RSVD12 12
`define PPCS_CR_RSVD11 11
`define PPCS_CR_MDIX_DIS 10
`define PPCS_CR_FORCE_MDI 9
`define PPCS_CR_RSVD8 8
`define PPCS_CR_AN_EN 7
`define PPCS_CR_SPEED 6
`define PPCS_CR_DUPLEX 5
`define PPCS_CR_ABIL_HI 4

// Basic control mirror fields
`define PPCS_BC_LED_OFF 0
`define PPCS_BC_TX_DIS 1
`define PPCS_BC_MDIX_DIS 3
`define PPCS_BC_FORCE_MDI 4
`define PPCS_BC_VARIANT 5
`define PPCS_BC_DUPLEX 8
`define PPCS_BC_RESTART 9
`define PPCS_BC_AN_EN 12
`define PPCS_BC_SPEED 13

// Status register fields
`define PPCS_SR_VARIANT 15
`define PPCS_SR_POL_REV 13
`define PPCS_SR_SPEED 10
`define PPCS_SR_DUPLEX 9
`define PPCS_SR_MDI 7
`define PPCS_SR_AN_DONE 6
`define PPCS_SR_LINK 5

// Basic status mirror fields
`define PPCS_BS_AN_DONE 5
`define PPCS_BS_LINK 2

// Ability bit positions in advertisement/partner layout
`define PPCS_AB_PAUSE 10
`define PPCS_AB_100F 8
`define PPCS_AB_100H 7
`define PPCS_AB_10F 6
`define PPCS_AB_10H 5
`define PPCS_ADV_RSVD9 9
`define PPCS_SELECTOR 5'h01

// Reset values and the blanked LED pattern
`define PPCS_RST_ABIL 5'h1f
`define PPCS_RST_AN_EN 1'h1
`define PPCS_RST_SPEED 1'h1
`define PPCS_RST_DUPLEX 1'h1
`define PPCS_RST_VARIANT 1'h1
`define PPCS_LED_BLANK 4'hf

`endif

// *** hdl/ppcs_port_regs.v ***
// Per-port PHY control and status registers with their standard-register mirrors.
// Assumes PHY status inputs are synchronous to clk_sys_i; the PHY core acts on the control outputs.
`timescale 1ns/10ps
`include "ppcs_consts.vh"

module ppcs_port_regs #(
  parameter ADDR_W = `PPCS_ADDR_W,
  parameter DATA_W = `PPCS_DATA_W
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // Register port
  input wire [ADDR_W-1:0] reg_addr_i,
  input wire [DATA_W-1:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [DATA_W-1:0] reg_rdata_o,
  // Status from the PHY core
  input wire phy_pol_rev_i,
  input wire phy_speed_100_i,
  input wire phy_full_duplex_i,
  input wire phy_mdi_i,
  input wire phy_an_done_i,
  input wire phy_link_good_i,
  input wire [4:0] phy_partner_abil_i,
  input wire [3:0] led_normal_i,
  // Control to the PHY core and pins
  output wire [3:0] port_led_out_o,
  output wire tx_disable_o,
  output reg an_restart_o,
  output wire an_enable_o,
  output wire force_speed_100_o,
  output wire force_full_duplex_o,
  output wire mdix_auto_disable_o,
  output wire force_mdi_o,
  output wire crossover_variant_select_o,
  output wire [4:0] advertise_abil_o
);

  reg led_off_reg;
  reg tx_dis_reg;
  reg restart_reg;
  reg [2:0] rsvd_ctrl_reg;
  reg mdix_dis_reg;
  reg force_mdi_reg;
  reg an_en_reg;
  reg speed_reg;
  reg duplex_reg;
  reg variant_reg;
  reg [4:0] adv_reg;
  reg adv_rsvd9_reg;
  // Next values of the stored fields
  reg led_off_next;
  reg tx_dis_next;
  reg restart_next;
  reg [2:0] rsvd_ctrl_next;
  reg mdix_dis_next;
  reg force_mdi_next;
  reg an_en_next;
  reg speed_next;
  reg duplex_next;
  reg variant_next;
  reg [4:0] adv_next;
  reg adv_rsvd9_next;
  reg [DATA_W-1:0] rd_next;

  wire wr_ctrl = reg_wr_i && (reg_addr_i == `PPCS_OFF_CONTROL);
  wire wr_bctl = reg_wr_i && (reg_addr_i == `PPCS_OFF_BASIC_CTRL);
  wire wr_adv = reg_wr_i && (reg_addr_i == `PPCS_OFF_ADVERTISE);
  wire wr_stat = reg_wr_i && (reg_addr_i == `PPCS_OFF_STATUS);
  // Reserved window after the status register
  wire rd_rsvd = (reg_addr_i >= `PPCS_OFF_RSVD_LO) && (reg_addr_i <= `PPCS_OFF_RSVD_HI);

  // Next values; a write through either alias lands in the same flop
  always @* begin
    led_off_next = led_off_reg;
    tx_dis_next = tx_dis_reg;
    // The restart request is consumed one cycle after it is written
    restart_next = 1'h0;
    rsvd_ctrl_next = rsvd_ctrl_reg;
    mdix_dis_next = mdix_dis_reg;
    force_mdi_next = force_mdi_reg;
    an_en_next = an_en_reg;
    speed_next = speed_reg;
    duplex_next = duplex_reg;
    variant_next = variant_reg;
    adv_next = adv_reg;
    adv_rsvd9_next = adv_rsvd9_reg;
    if (wr_ctrl) begin
      led_off_next = reg_wdata_i[`PPCS_CR_LED_OFF];
      tx_dis_next = reg_wdata_i[`PPCS_CR_TX_DIS];
      restart_next = reg_wdata_i[`PPCS_CR_RESTART];
      rsvd_ctrl_next[2] = reg_wdata_i[`PPCS_CR_RSVD12];
      rsvd_ctrl_next[1] = reg_wdata_i[`PPCS_CR_RSVD11];
      rsvd_ctrl_next[0] = reg_wdata_i[`PPCS_CR_RSVD8];
      mdix_dis_next = reg_wdata_i[`PPCS_CR_MDIX_DIS];
      force_mdi_next = reg_wdata_i[`PPCS_CR_FORCE_MDI];
      an_en_next = reg_wdata_i[`PPCS_CR_AN_EN];
      speed_next = reg_wdata_i[`PPCS_CR_SPEED];
      duplex_next = reg_wdata_i[`PPCS_CR_DUPLEX];
      adv_next = reg_wdata_i[`PPCS_CR_ABIL_HI:0];
    end
    if (wr_bctl) begin
      led_off_next = reg_wdata_i[`PPCS_BC_LED_OFF];
      tx_dis_next = reg_wdata_i[`PPCS_BC_TX_DIS];
      restart_next = reg_wdata_i[`PPCS_BC_RESTART];
      mdix_dis_next = reg_wdata_i[`PPCS_BC_MDIX_DIS];
      force_mdi_next = reg_wdata_i[`PPCS_BC_FORCE_MDI];
      variant_next = reg_wdata_i[`PPCS_BC_VARIANT];
      an_en_next = reg_wdata_i[`PPCS_BC_AN_EN];
      speed_next = reg_wdata_i[`PPCS_BC_SPEED];
      duplex_next = reg_wdata_i[`PPCS_BC_DUPLEX];
    end
    if (wr_adv) begin
      adv_next[4] = reg_wdata_i[`PPCS_AB_PAUSE];
      adv_next[3] = reg_wdata_i[`PPCS_AB_100F];
      adv_next[2] = reg_wdata_i[`PPCS_AB_100H];
      adv_next[1] = reg_wdata_i[`PPCS_AB_10F];
      adv_next[0] = reg_wdata_i[`PPCS_AB_10H];
      adv_rsvd9_next = reg_wdata_i[`PPCS_ADV_RSVD9];
    end
    if (wr_stat) begin
      variant_next = reg_wdata_i[`PPCS_SR_VARIANT];
    end
  end

  // One flop per field, so each reset value sits beside its register
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      led_off_reg <= 1'h0;
    end else begin
      led_off_reg <= led_off_next;
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      tx_dis_reg <= 1'h0;
    end else begin
      tx_dis_reg <= tx_dis_next;
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      restart_reg <= 1'h0;
    end else begin
      restart_reg <= restart_next;
    end
  end

  // Reserved bits only store; nothing in the PHY core reads them
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      rsvd_ctrl_reg <= 3'h0;
    end else begin
      rsvd_ctrl_reg <= rsvd_ctrl_next;
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      mdix_dis_reg <= 1'h0;
    end else begin
      mdix_dis_reg <= mdix_dis_next;
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      force_mdi_reg <= 1'h0;
    end else begin
      force_mdi_reg <= force_mdi_next;
    end
  end

  // Negotiation on by default, so a cable link comes up untouched
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      an_en_reg <= `PPCS_RST_AN_EN;
    end else begin
      an_en_reg <= an_en_next;
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      speed_reg <= `PPCS_RST_SPEED;
    end else begin
      speed_reg <= speed_next;
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      duplex_reg <= `PPCS_RST_DUPLEX;
    end else begin
      duplex_reg <= duplex_next;
    end
  end

  // Shared by status bit 15 and basic control bit 5
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      variant_reg <= `PPCS_RST_VARIANT;
    end else begin
      variant_reg <= variant_next;
    end
  end

  // All abilities advertised after reset
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      adv_reg <= `PPCS_RST_ABIL;
    end else begin
      adv_reg <= adv_next;
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      adv_rsvd9_reg <= 1'h0;
    end else begin
      adv_rsvd9_reg <= adv_rsvd9_next;
    end
  end

  // Restart pulse to the PHY core, two cycles after the write
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      an_restart_o <= 1'h0;
    end else begin
      an_restart_o <= restart_reg;
    end
  end

  // LED pins idle high when blanked
  assign port_led_out_o = led_off_reg ? `PPCS_LED_BLANK : led_normal_i;
  assign tx_disable_o = tx_dis_reg;
  assign mdix_auto_disable_o = mdix_dis_reg;
  // Forced wiring only matters while auto crossover is off
  assign force_mdi_o = mdix_dis_reg & force_mdi_reg;
  assign an_enable_o = an_en_reg;
  assign force_speed_100_o = speed_reg;
  // Duplex fallback also used when negotiation fails; PHY core decides when
  assign force_full_duplex_o = duplex_reg;
  assign advertise_abil_o = adv_reg;
  assign crossover_variant_select_o = variant_reg;

  // Read mux; unmapped and reserved addresses read zero
  always @* begin
    rd_next = 16'h0000;
    case (reg_addr_i)
      `PPCS_OFF_CONTROL: begin
        rd_next[`PPCS_CR_LED_OFF] = led_off_reg;
        rd_next[`PPCS_CR_TX_DIS] = tx_dis_reg;
        rd_next[`PPCS_CR_RESTART] = restart_reg;
        rd_next[`PPCS_CR_RSVD12] = rsvd_ctrl_reg[2];
        rd_next[`PPCS_CR_RSVD11] = rsvd_ctrl_reg[1];
        rd_next[`PPCS_CR_RSVD8] = rsvd_ctrl_reg[0];
        rd_next[`PPCS_CR_MDIX_DIS] = mdix_dis_reg;
        rd_next[`PPCS_CR_FORCE_MDI] = force_mdi_reg;
        rd_next[`PPCS_CR_AN_EN] = an_en_reg;
        rd_next[`PPCS_CR_SPEED] = speed_reg;
        rd_next[`PPCS_CR_DUPLEX] = duplex_reg;
        rd_next[4:0] = adv_reg;
      end
      `PPCS_OFF_BASIC_CTRL: begin
        rd_next[`PPCS_BC_LED_OFF] = led_off_reg;
        rd_next[`PPCS_BC_TX_DIS] = tx_dis_reg;
        rd_next[`PPCS_BC_MDIX_DIS] = mdix_dis_reg;
        rd_next[`PPCS_BC_FORCE_MDI] = force_mdi_reg;
        rd_next[`PPCS_BC_VARIANT] = variant_reg;
        rd_next[`PPCS_BC_DUPLEX] = duplex_reg;
        rd_next[`PPCS_BC_RESTART] = restart_reg;
        rd_next[`PPCS_BC_AN_EN] = an_en_reg;
        rd_next[`PPCS_BC_SPEED] = speed_reg;
      end
      `PPCS_OFF_ADVERTISE: begin
        rd_next[`PPCS_AB_PAUSE] = adv_reg[4];
        rd_next[`PPCS_ADV_RSVD9] = adv_rsvd9_reg;
        rd_next[`PPCS_AB_100F] = adv_reg[3];
        rd_next[`PPCS_AB_100H] = adv_reg[2];
        rd_next[`PPCS_AB_10F] = adv_reg[1];
        rd_next[`PPCS_AB_10H] = adv_reg[0];
        rd_next[4:0] = `PPCS_SELECTOR;
      end
      `PPCS_OFF_PARTNER: begin
        rd_next[`PPCS_AB_PAUSE] = phy_partner_abil_i[4];
        rd_next[`PPCS_AB_100F] = phy_partner_abil_i[3];
        rd_next[`PPCS_AB_100H] = phy_partner_abil_i[2];
        rd_next[`PPCS_AB_10F] = phy_partner_abil_i[1];
        rd_next[`PPCS_AB_10H] = phy_partner_abil_i[0];
        rd_next[4:0] = `PPCS_SELECTOR;
      end
      `PPCS_OFF_BASIC_STAT: begin
        rd_next[`PPCS_BS_AN_DONE] = phy_an_done_i;
        rd_next[`PPCS_BS_LINK] = phy_link_good_i;
      end
      `PPCS_OFF_STATUS: begin
        rd_next[`PPCS_SR_VARIANT] = variant_reg;
        rd_next[`PPCS_SR_POL_REV] = phy_pol_rev_i;
        rd_next[`PPCS_SR_SPEED] = phy_speed_100_i;
        rd_next[`PPCS_SR_DUPLEX] = phy_full_duplex_i;
        rd_next[`PPCS_SR_MDI] = phy_mdi_i;
        rd_next[`PPCS_SR_AN_DONE] = phy_an_done_i;
        rd_next[`PPCS_SR_LINK] = phy_link_good_i;
        rd_next[4:0] = phy_partner_abil_i;
      end
      default: begin
        // Includes the reserved block after the status register
        rd_next = 16'h0000;
      end
    endcase
  end

  // Read data valid only in the cycle after the read strobe
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i && !rd_rsvd) begin
      reg_rdata_o <= rd_next;
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

endmodule // ppcs_port_regs

// *** sim/ppcs_phy_model.sv ***
// Behavioural PHY core and cable partner feeding the status inputs.
// Assumes the control levels of ppcs_port_regs on clk_sys_i.
`timescale 1ns/10ps
module ppcs_phy_model (
  // Clock, cable state and control levels
  input wire clk_sys_i, link_i, restart_i, an_en_i, spd_i, dup_i, mdx_dis_i, mdi_sel_i,
  input wire [4:0] abil_i,
  // Status back to the registers
  output reg an_done_o = 1'h0,
  output wire spd_o, dup_o, mdi_o,
  output wire [4:0] abil_o
);
  // A restart throws the last result away, as a real partner would
  always @(posedge clk_sys_i) begin
    an_done_o <= an_en_i && link_i && !restart_i;
  end
  assign spd_o = an_en_i ? |abil_i[3:2] : spd_i;
  // A negotiation that has not finished falls back to the forced duplex
  assign dup_o = an_en_i && an_done_o ? abil_i[3] | abil_i[1] : dup_i;
  assign mdi_o = mdx_dis_i ? mdi_sel_i : 1'h1;
  assign abil_o = an_done_o ? abil_i : 5'h00;
endmodule // ppcs_phy_model

// *** sim/ppcs_port_regs_asserts.sv ***
// Checker for ppcs_port_regs, bound to its ports.
// Assumes one clock domain and the synchronous reset.
`timescale 1ns/10ps
module ppcs_port_regs_asserts (
  // Ports of the watched block
  input wire clk_sys_i, reset_i, reg_wr_i, reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [15:0] reg_wdata_i, reg_rdata_o,
  input wire [3:0] led_normal_i, port_led_out_o,
  input wire tx_disable_o, an_restart_o, an_enable_o, force_speed_100_o, force_full_duplex_o,
  input wire mdix_auto_disable_o, force_mdi_o, crossover_variant_select_o,
  input wire [4:0] advertise_abil_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  wire [15:0] w = reg_wdata_i;
  wire wcr = reg_wr_i && reg_addr_i == 8'hf6;
  wire [3:0] ctl = {tx_disable_o, an_enable_o, force_speed_100_o, force_full_duplex_o};
  AST_LED: assert property (wcr |=> port_led_out_o == ($past(w[15]) ? 4'hf : led_normal_i))
    else $error("LED outputs wrong");
  AST_CTRL: assert property (wcr |=> ctl == $past({w[14], w[7:5]}))
    else $error("control levels wrong");
  AST_RESTART: assert property (wcr && w[13] |-> ##2 an_restart_o ##1 !an_restart_o)
    else $error("restart pulse wrong");
  AST_MDIX: assert property (wcr |=> mdix_auto_disable_o == $past(w[10]) && force_mdi_o == $past(w[10] & w[9]))
    else $error("crossover control wrong");
  AST_ADV: assert property (wcr |=> advertise_abil_o == $past(w[4:0]))
    else $error("advertised abilities wrong");
  AST_ADV_MIR: assert property (reg_wr_i && reg_addr_i == 8'hec |=> advertise_abil_o == $past({w[10], w[8:5]}))
    else $error("advertisement alias wrong");
  AST_BC: assert property (reg_wr_i && reg_addr_i == 8'he0 |=> ctl == $past({w[1], w[12], w[13], w[8]}))
    else $error("basic control alias wrong");
  AST_VAR: assert property (reg_wr_i && reg_addr_i == 8'hf8 |=> crossover_variant_select_o == $past(w[15]))
    else $error("variant select wrong");
  AST_RSVD: assert property (reg_rd_i && reg_addr_i >= 8'hfa |=> reg_rdata_o == 16'h0000)
    else $error("reserved read not zero");
  cover property (wcr && w[13]);
  cover property (reg_wr_i && reg_addr_i == 8'he0);
  cover property (reg_rd_i && reg_addr_i >= 8'hfa);
endmodule // ppcs_port_regs_asserts

bind ppcs_port_regs ppcs_port_regs_asserts i_ppcs_port_regs_asserts (.*);

// *** sim/test_ppcs_port_regs.sv ***
// Self-checking bench for ppcs_port_regs with a behavioural PHY model.
// Assumes the read answer stands only in the cycle after the strobe.
`timescale 1ns/10ps
module test_ppcs_port_regs;
  reg clk_sys_i = 1'h0, reset_i = 1'h1, reg_wr_i = 1'h0, reg_rd_i = 1'h0, phy_link_good_i = 1'h0, phy_pol_rev_i = 1'h0;
  reg [7:0] reg_addr_i = 8'h00;
  reg [15:0] reg_wdata_i = 16'h0000, n;
  reg [4:0] abil = 5'h1f;
  wire [15:0] reg_rdata_o;
  wire [4:0] phy_partner_abil_i, advertise_abil_o;
  wire [3:0] port_led_out_o;
  wire phy_an_done_i, phy_speed_100_i, phy_full_duplex_i, phy_mdi_i, tx_disable_o, an_restart_o, an_enable_o;
  wire force_speed_100_o, force_full_duplex_o, mdix_auto_disable_o, force_mdi_o, crossover_variant_select_o;
  wire [3:0] led_normal_i = {phy_link_good_i, phy_speed_100_i, phy_full_duplex_i, 1'h0};
  integer err_count = 0, checked = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  ppcs_port_regs i_ppcs_port_regs (.*);
  ppcs_phy_model i_ppcs_phy_model (.clk_sys_i, .link_i(phy_link_good_i), .restart_i(an_restart_o),
    .an_en_i(an_enable_o), .spd_i(force_speed_100_o), .dup_i(force_full_duplex_o), .mdx_dis_i(mdix_auto_disable_o),
    .mdi_sel_i(force_mdi_o), .abil_i(abil), .an_done_o(phy_an_done_i), .spd_o(phy_speed_100_i),
    .dup_o(phy_full_duplex_i), .mdi_o(phy_mdi_i), .abil_o(phy_partner_abil_i));
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    checked = checked + 1;
    if (s !== e) begin
      err_count = err_count + 1;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One strobe cycle; a read compares the answer standing in the next cycle
  task acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} <= {w, !w, a, d};
    @(posedge clk_sys_i);
    {reg_wr_i, reg_rd_i} <= 2'h0;
    #1;
    if (!w) chk("rdata", reg_rdata_o, d);
  endtask
  task end_of_test;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk_sys_i);
    err_count = err_count + 1;
    end_of_test;
  end
  initial begin
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    acc(0, 8'hf6, 16'h00ff);
    acc(0, 8'hf8, 16'h8680);
    chk("led", port_led_out_o, 16'h0006);
    $display("test reset values done");
    @(posedge clk_sys_i) {phy_link_good_i, phy_pol_rev_i} <= 2'h3;
    acc(1, 8'hf6, 16'hcf1a);
    chk("led", port_led_out_o, 16'h000f);
    acc(0, 8'hf6, 16'hcf1a);
    acc(0, 8'hec, 16'h0541);
    acc(0, 8'he0, 16'h003b);
    acc(0, 8'hf8, 16'ha0a0);
    acc(1, 8'hf6, 16'h0400);
    acc(0, 8'hf8, 16'ha020);
    $display("test forced mode done");
    acc(1, 8'hf6, 16'h20ff);
    n = 16'h0000;
    repeat (6) begin
      @(posedge clk_sys_i);
      #1 n = n + an_restart_o;
    end
    chk("restart pulses", n, 16'h0001);
    acc(0, 8'hf6, 16'h00ff);
    acc(0, 8'hf8, 16'ha6ff);
    acc(0, 8'hee, 16'h05e1);
    $display("test negotiation restart done");
    acc(1, 8'hec, 16'h0200);
    acc(0, 8'hf6, 16'h00e0);
    acc(1, 8'hf8, 16'h0000);
    acc(0, 8'he0, 16'h3100);
    acc(1, 8'he0, 16'h0020);
    acc(0, 8'hf8, 16'ha0a0);
    $display("test mirrors done");
    acc(1, 8'hfa, 16'hffff);
    for (int a = 8'hf9; a <= 8'hff; a++) acc(0, a[7:0], 16'h0000);
    acc(0, 8'hf6, 16'h0000);
    $display("test reserved done");
    end_of_test;
  end
endmodule // test_ppcs_port_regs
